/* File: src/pbl_regs.svh */
// opcodes, field positions, reset values and cycle counts of the pair/bit load unit
`ifndef PBL_REGS_SVH
`define PBL_REGS_SVH
// first opcode bytes
`define PBL_OPC_EXT        8'hDC
`define PBL_OPC_LD_EA_DA   8'hCE
`define PBL_OPC_ST_EA_DA   8'hCD
`define PBL_OPC_ST_A_HL    8'hC4
`define PBL_OPC_BIT_TO_MEM 8'hFC
`define PBL_OPC_BIT_TO_C   8'hF4
// second bytes behind the extension opcode
`define PBL_SUB_LD_EA_HL   8'h08
`define PBL_SUB_ST_EA_HL   8'h00
`define PBL_SUB_EA_RR      5'h1F
`define PBL_SUB_RR_EA      5'h1E
// bit operand fields
`define PBL_MEMA_FLAG      7
`define PBL_MEMA_PORT      6
`define PBL_MEMB_TAG       4'h4
`define PBL_PORT_PAGE      4'hF
`define PBL_MEMA_RAM_PAGE  4'hB
// register file nibble slots
`define PBL_IDX_A          3'h0
`define PBL_IDX_E          3'h1
`define PBL_IDX_L          3'h2
`define PBL_IDX_H          3'h3
// reset values
`define PBL_NIB_RST        4'h0
`define PBL_PINS_RST       16'h0000
`define PBL_OE_N_RST       16'hFFFF
// execution length of two-cycle instructions
`define PBL_EXEC_CYCLES    2
`endif

/* File: src/pbl_pkg.sv */
// types shared by the pair/bit load unit
package pbl_pkg;
   typedef logic [3:0] pbl_nib_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CYC1 = 2'b01,
      ST_CYC2 = 2'b10
   } pbl_state_e;
endpackage

/* File: src/pbl_mem_if.sv */
// link between the execution unit and its nibble data memory
`timescale 1ns/100ps
interface pbl_mem_if;
   logic                ce;
   logic                rd_en;
   logic [6:0]          rd_addr;
   pbl_pkg::pbl_nib_t   rd_lo;
   pbl_pkg::pbl_nib_t   rd_hi;
   logic                wr_en;
   logic [7:0]          wr_addr;
   pbl_pkg::pbl_nib_t   wr_data;
   modport exec (output ce, rd_en, rd_addr, wr_en, wr_addr, wr_data, input rd_lo, rd_hi);
   modport mem  (input ce, rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_lo, rd_hi);
endinterface

/* File: src/pbl_mem.sv */
// 256 x 4 data memory split into even and odd banks, registered pair read
`timescale 1ns/100ps
`include "pbl_regs.svh"
module pbl_mem (
   input  wire logic clk_in,
   input  wire logic rst_in,
   pbl_mem_if.mem    m
);
   pbl_pkg::pbl_nib_t lo_bank [128];
   pbl_pkg::pbl_nib_t hi_bank [128];

   always_ff @(posedge clk_in) begin
      if (m.ce && m.wr_en && m.wr_addr[0]) begin
         hi_bank[m.wr_addr[7:1]] <= m.wr_data;
      end
      if (m.ce && m.wr_en && !m.wr_addr[0]) begin
         lo_bank[m.wr_addr[7:1]] <= m.wr_data;
      end
   end

   // both nibbles of an even-aligned pair come out together
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         m.rd_lo <= `PBL_NIB_RST;
         m.rd_hi <= `PBL_NIB_RST;
      end else if (m.ce && m.rd_en) begin
         m.rd_lo <= lo_bank[m.rd_addr];
         m.rd_hi <= hi_bank[m.rd_addr];
      end
   end
endmodule

/* File: src/pbl_exec.sv */
// execution unit for register-pair loads/stores and single-bit carry loads
`timescale 1ns/100ps
`include "pbl_regs.svh"
// Functional notes
// - pair load via primary pointer: A gets the even nibble of the addressed pair, E the odd one
// - primary pointer pair access ignores low pointer LSB; pointer keeps its value
// - pair load from direct address: A from even address, E from following
// - pair store to direct address: A to even address, E to next; operand kept
// - copy pointer pair to accumulator: upper nibble to E, lower to A
// - copy accumulator to pointer pair: E to upper nibble, A to lower
// - single nibble store writes A at the full 8-bit primary pointer address
// - pair store via primary pointer: A to even address, E to next
// - bit move copies between carry and a memory bit; source unchanged
// - every bit move form takes two instruction cycles
// - low pointer bit form: address from operand and L[3:2], bit from L[1:0]
// - high pointer bit form: address H with operand low nibble, field picks bit
// - carry written to a port bit at addresses F0-F3 drives the pin and turns it to output
module pbl_exec (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic        start_in,
   input  wire logic [7:0]  op1_in,
   input  wire logic [7:0]  op2_in,
   input  wire logic        reg_wr_in,
   input  wire logic [2:0]  reg_sel_in,
   input  wire logic [3:0]  reg_data_in,
   input  wire logic        carry_wr_in,
   input  wire logic        carry_data_in,
   input  wire logic [15:0] pin_in,
   output logic      [7:0]  extended_accumulator_out,
   output logic      [7:0]  primary_pointer_pair_out,
   output logic      [7:0]  second_pointer_pair_out,
   output logic      [7:0]  third_pointer_pair_out,
   output logic             carry_out,
   output logic             busy_out,
   output logic             done_out,
   output logic      [15:0] pin_out,
   output logic      [15:0] pin_oe_n_out
);
   pbl_mem_if mi ();

   pbl_mem u_mem (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .m      (mi.mem)
   );

   pbl_pkg::pbl_state_e st;
   pbl_pkg::pbl_state_e next_st;
   pbl_pkg::pbl_nib_t   rf [8];
   pbl_pkg::pbl_nib_t   next_rf [8];
   logic [7:0]          op1;
   logic [7:0]          op2;
   logic                carry;
   logic                next_carry;
   logic                next_done;
   logic [15:0]         pins;
   logic [15:0]         oe_n;

   // even pair index: direct operand or primary pointer, LSB dropped
   function automatic logic [6:0] pair_idx(input logic direct, input logic [7:0] da,
                                           input logic [3:0] hp, input logic [3:0] lp);
      pair_idx = direct ? da[7:1] : {hp, lp[3:1]};
   endfunction

   // nibble address and bit number of a bit operand, packed {addr, bit}
   function automatic logic [9:0] bit_loc(input logic [7:0] b, input logic [3:0] hp,
                                          input logic [3:0] lp);
      if (b[`PBL_MEMA_FLAG]) begin
         bit_loc = {(b[`PBL_MEMA_PORT] ? `PBL_PORT_PAGE : `PBL_MEMA_RAM_PAGE), b[3:0], b[5:4]};
      end else if (b[7:4] == `PBL_MEMB_TAG) begin
         bit_loc = {2'b11, b[3:0], lp[3:2], lp[1:0]};
      end else begin
         bit_loc = {hp, b[3:0], b[5:4]};
      end
   endfunction

   function automatic logic [3:0] put_bit(input logic [3:0] n, input logic [1:0] i,
                                          input logic v);
      put_bit = n;
      put_bit[i] = v;
   endfunction

   // instruction decode on the latched opcode bytes
   wire logic       is_ext      = op1 == `PBL_OPC_EXT;
   wire logic       op_ld_ea_hl = is_ext && op2 == `PBL_SUB_LD_EA_HL;
   wire logic       op_st_ea_hl = is_ext && op2 == `PBL_SUB_ST_EA_HL;
   wire logic       op_ea_rr    = is_ext && op2[7:3] == `PBL_SUB_EA_RR && !op2[0];
   wire logic       op_rr_ea    = is_ext && op2[7:3] == `PBL_SUB_RR_EA && !op2[0];
   wire logic       op_ld_ea_da = op1 == `PBL_OPC_LD_EA_DA;
   wire logic       op_st_ea_da = op1 == `PBL_OPC_ST_EA_DA;
   wire logic       op_st_a_hl  = op1 == `PBL_OPC_ST_A_HL;
   wire logic       op_bit_mem  = op1 == `PBL_OPC_BIT_TO_MEM;
   wire logic       op_bit_c    = op1 == `PBL_OPC_BIT_TO_C;
   wire logic       op_ea_load  = op_ld_ea_hl || op_ld_ea_da;
   wire logic       op_ea_store = op_st_ea_hl || op_st_ea_da;
   wire logic       op_bit      = op_bit_mem || op_bit_c;
   wire logic       direct      = op_ld_ea_da || op_st_ea_da;
   wire logic [1:0] rr          = op2[2:1];

   wire logic       go1   = ce_in && st == pbl_pkg::ST_CYC1;
   wire logic       go2   = ce_in && st == pbl_pkg::ST_CYC2;
   wire logic       taken = ce_in && st == pbl_pkg::ST_IDLE && start_in;
   wire logic       setup = ce_in && st == pbl_pkg::ST_IDLE && !start_in;

   wire logic [6:0] pair_base = pair_idx(direct, op2, rf[`PBL_IDX_H], rf[`PBL_IDX_L]);
   wire logic [9:0] bl        = bit_loc(op2, rf[`PBL_IDX_H], rf[`PBL_IDX_L]);
   wire logic [7:0] bit_addr  = bl[9:2];
   wire logic [1:0] bit_idx   = bl[1:0];
   wire logic       is_port   = bit_addr[7:4] == `PBL_PORT_PAGE;
   wire logic       port_ok   = is_port && bit_addr[3:2] == 2'b00;
   wire logic [3:0] pin       = {bit_addr[1:0], bit_idx};
   wire logic [3:0] bit_nib   = bit_addr[0] ? mi.rd_hi : mi.rd_lo;
   wire logic       bit_val   = is_port ? (port_ok && pin_in[pin]) : bit_nib[bit_idx];
   wire logic [3:0] new_nib   = put_bit(bit_nib, bit_idx, carry);

   // memory strobes: first cycle reads pairs or writes A, second writes E or the bit
   assign mi.ce      = ce_in;
   assign mi.rd_en   = go1 && (op_ea_load || op_bit);
   assign mi.rd_addr = op_bit ? bit_addr[7:1] : pair_base;
   assign mi.wr_en   = (go1 && (op_st_a_hl || op_ea_store))
                     || (go2 && (op_ea_store || (op_bit_mem && !is_port)));
   assign mi.wr_addr = go2 ? (op_bit ? bit_addr : {pair_base, 1'b1})
                     : (op_st_a_hl ? {rf[`PBL_IDX_H], rf[`PBL_IDX_L]}
                     : {pair_base, 1'b0});
   assign mi.wr_data = go2 ? (op_bit ? new_nib : rf[`PBL_IDX_E]) : rf[`PBL_IDX_A];

   always_comb begin
      next_st = st;
      next_done = 1'b0;
      case (st)
         pbl_pkg::ST_IDLE: begin
            if (start_in) begin
               next_st = pbl_pkg::ST_CYC1;
            end
         end
         pbl_pkg::ST_CYC1: begin
            next_st = op_st_a_hl ? pbl_pkg::ST_IDLE : pbl_pkg::ST_CYC2;
            next_done = op_st_a_hl;
         end
         pbl_pkg::ST_CYC2: begin
            next_st = pbl_pkg::ST_IDLE;
            next_done = 1'b1;
         end
         default: begin
            next_st = pbl_pkg::ST_IDLE;
         end
      endcase
   end

   always_comb begin
      next_rf = rf;
      if (setup && reg_wr_in) begin
         next_rf[reg_sel_in] = reg_data_in;
      end
      if (go2 && op_ea_load) begin
         next_rf[`PBL_IDX_A] = mi.rd_lo;
         next_rf[`PBL_IDX_E] = mi.rd_hi;
      end
      if (go2 && op_ea_rr) begin
         next_rf[`PBL_IDX_A] = rf[{rr, 1'b0}];
         next_rf[`PBL_IDX_E] = rf[{rr, 1'b1}];
      end
      if (go2 && op_rr_ea) begin
         next_rf[{rr, 1'b0}] = rf[`PBL_IDX_A];
         next_rf[{rr, 1'b1}] = rf[`PBL_IDX_E];
      end
   end

   always_comb begin
      next_carry = carry;
      if (setup && carry_wr_in) begin
         next_carry = carry_data_in;
      end
      if (go2 && op_bit_c) begin
         next_carry = bit_val;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st <= pbl_pkg::ST_IDLE;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         carry <= 1'b0;
      end else if (ce_in) begin
         st <= next_st;
         busy_out <= next_st != pbl_pkg::ST_IDLE;
         done_out <= next_done;
         carry <= next_carry;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         op1 <= 8'h00;
         op2 <= 8'h00;
      end else if (taken) begin
         op1 <= op1_in;
         op2 <= op2_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rf <= '{default: `PBL_NIB_RST};
      end else if (ce_in) begin
         rf <= next_rf;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pins <= `PBL_PINS_RST;
         oe_n <= `PBL_OE_N_RST;
      end else if (go2 && op_bit_mem && port_ok) begin
         pins[pin] <= carry;
         oe_n[pin] <= 1'b0;
      end
   end

   assign extended_accumulator_out = {rf[1], rf[0]};
   assign primary_pointer_pair_out = {rf[3], rf[2]};
   assign second_pointer_pair_out  = {rf[5], rf[4]};
   assign third_pointer_pair_out   = {rf[7], rf[6]};
   assign carry_out                = carry;
   assign pin_out                  = pins;
   assign pin_oe_n_out             = oe_n;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_bit_taken;
      taken && (op1_in == `PBL_OPC_BIT_TO_MEM || op1_in == `PBL_OPC_BIT_TO_C);
   endsequence
   sequence s_two_run;
      ce_in ##1 ce_in;
   endsequence

   // issue-level checks
   a_bit_two_cycles: assert property (
      s_bit_taken ##1 s_two_run |=> done_out && !busy_out)
      else $error("bit move did not finish in two cycles");
   a_done_pulse: assert property (done_out && ce_in |=> !done_out)
      else $error("done held longer than one enabled cycle");
   a_busy_in_run: assert property (go1 || go2 |-> busy_out)
      else $error("busy low while executing");
   a_hl_pair_even: assert property (
      go1 && (op_ld_ea_hl || op_st_ea_hl)
      |-> (op_st_ea_hl ? mi.wr_addr == {rf[`PBL_IDX_H], rf[`PBL_IDX_L][3:1], 1'h0}
                       : mi.rd_addr == {rf[`PBL_IDX_H], rf[`PBL_IDX_L][3:1]})
          ##1 rf[`PBL_IDX_L] == $past(rf[`PBL_IDX_L]))
      else $error("pointer pair addressing not even aligned or pointer changed");
   a_ea_load_data: assert property (go2 && op_ea_load
      |=> extended_accumulator_out == {$past(mi.rd_hi), $past(mi.rd_lo)})
      else $error("pair load put wrong nibbles in accumulator");
   a_direct_rd_addr: assert property (go1 && op_ld_ea_da |-> mi.rd_addr == op2[7:1])
      else $error("direct pair load address not forced even");
   a_direct_store: assert property (go1 && op_st_ea_da
      |-> mi.wr_en && mi.wr_addr == {op2[7:1], 1'b0} && mi.wr_data == rf[`PBL_IDX_A]
      ##1 (!ce_in || (mi.wr_addr == {op2[7:1], 1'b1} && mi.wr_data == rf[`PBL_IDX_E])))
      else $error("direct pair store wrote wrong place or data");
   a_hl_store_lo: assert property (go1 && op_st_ea_hl |-> mi.wr_en && mi.wr_data == rf[0])
      else $error("pointer pair store low nibble data wrong");
   a_hl_pair_store: assert property (go2 && op_st_ea_hl
      |-> mi.wr_en && mi.wr_addr == {rf[`PBL_IDX_H], rf[`PBL_IDX_L][3:1], 1'h1}
          && mi.wr_data == rf[`PBL_IDX_E])
      else $error("pointer pair store high nibble misplaced");
   a_single_store: assert property (go1 && op_st_a_hl
      |-> mi.wr_en && mi.wr_data == rf[`PBL_IDX_A]
          && mi.wr_addr == primary_pointer_pair_out ##1 done_out)
      else $error("single nibble store address wrong");
   a_pair_to_ea: assert property (go2 && op_ea_rr
      |=> extended_accumulator_out == {$past(rf[{rr, 1'b1}]), $past(rf[{rr, 1'b0}])})
      else $error("pointer pair copy to accumulator wrong");
   a_ea_to_pair: assert property (go2 && op_rr_ea && rr != 2'b00
      |=> {rf[{rr, 1'b1}], rf[{rr, 1'b0}]} == $past(extended_accumulator_out))
      else $error("accumulator copy to pointer pair wrong");
   a_low_ptr_bit: assert property (go1 && op_bit && op2[7:4] == `PBL_MEMB_TAG
      |-> bit_addr == {2'b11, op2[3:0], rf[`PBL_IDX_L][3:2]}
          && bit_idx == rf[`PBL_IDX_L][1:0])
      else $error("low pointer bit address wrong");
   a_high_ptr_bit: assert property (
      go1 && op_bit && !op2[7] && op2[7:4] != `PBL_MEMB_TAG
      |-> bit_addr == {rf[`PBL_IDX_H], op2[3:0]} && bit_idx == op2[5:4])
      else $error("high pointer bit address wrong");
   a_carry_from_bit: assert property (go2 && op_bit_c && !is_port
      |=> carry_out == $past(bit_nib[bit_idx]))
      else $error("carry not loaded from memory bit");
   a_port_drive: assert property (go2 && op_bit_mem && port_ok
      |=> !pin_oe_n_out[$past(pin)] && pin_out[$past(pin)] == $past(carry))
      else $error("port pin not driven with carry");

   // bit move side effects: only the destination changes
   sequence s_bit_write;
      go2 && op_bit_mem && !is_port;
   endsequence
   a_bit_mem_write: assert property (
      s_bit_write |-> mi.wr_en && mi.wr_addr == bit_addr && mi.wr_data[bit_idx] == carry)
      else $error("memory bit not written with carry");
   a_bit_src_kept: assert property (go2 && op_bit_c |-> !mi.wr_en)
      else $error("bit move to carry wrote memory");
   a_carry_kept: assert property (go2 && op_bit_mem |=> carry_out == $past(carry_out))
      else $error("bit move to memory changed carry");
   a_port_no_mem: assert property (go2 && op_bit_mem && is_port |-> !mi.wr_en)
      else $error("port bit write reached data memory");
endmodule

/* File: tb/pbl_pin_model.sv */
// port pin model: released pins follow the outside level, driven pins the output latch
`timescale 1ns/100ps
module pbl_pin_model (
   input  wire logic [15:0] pin_out_in,
   input  wire logic [15:0] pin_oe_n_in,
   input  wire logic [15:0] ext_level_in,
   output logic      [15:0] pin_level_out
);
   // an enabled pin shows its latch, a released one whatever the outside drives
   assign pin_level_out = (pin_out_in & ~pin_oe_n_in) | (ext_level_in & pin_oe_n_in);
endmodule

/* File: tb/test_pair_and_bit_load_exec.sv */
// self-checking bench for the pair and bit load execution unit
`timescale 1ns/100ps
module test_pair_and_bit_load_exec;
   logic        clk_in        = 1'h0;
   logic        rst_in        = 1'h1;
   logic        ce_in         = 1'h1;
   logic        start_in      = 1'h0;
   logic [7:0]  op1_in        = 8'h00;
   logic [7:0]  op2_in        = 8'h00;
   logic        reg_wr_in     = 1'h0;
   logic [2:0]  reg_sel_in    = 3'h0;
   logic [3:0]  reg_data_in   = 4'h0;
   logic        carry_wr_in   = 1'h0;
   logic        carry_data_in = 1'h0;
   logic [15:0] ext_level     = 16'hFFFF;
   logic [15:0] pin_in;
   logic [7:0]  ea;
   logic [7:0]  hl;
   logic [7:0]  wx;
   logic [7:0]  yz;
   logic        carry_out;
   logic        busy_out;
   logic        done_out;
   logic [15:0] pin_out;
   logic [15:0] pin_oe_n_out;
   int          n_mismatch    = 0;
   int          num_checks    = 0;

   always #2 clk_in = ~clk_in;

   pbl_exec DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .start_in(start_in),
      .op1_in(op1_in), .op2_in(op2_in), .reg_wr_in(reg_wr_in), .reg_sel_in(reg_sel_in),
      .reg_data_in(reg_data_in), .carry_wr_in(carry_wr_in), .carry_data_in(carry_data_in),
      .pin_in(pin_in), .extended_accumulator_out(ea), .primary_pointer_pair_out(hl),
      .second_pointer_pair_out(wx), .third_pointer_pair_out(yz), .carry_out(carry_out),
      .busy_out(busy_out), .done_out(done_out), .pin_out(pin_out),
      .pin_oe_n_out(pin_oe_n_out));

   pbl_pin_model pins (.pin_out_in(pin_out), .pin_oe_n_in(pin_oe_n_out),
      .ext_level_in(ext_level), .pin_level_out(pin_in));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (n_mismatch == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic set_nib(input logic [2:0] sel, input logic [3:0] val);
      @(posedge clk_in);
      reg_wr_in   <= 1'h1;
      reg_sel_in  <= sel;
      reg_data_in <= val;
      @(posedge clk_in);
      reg_wr_in   <= 1'h0;
   endtask

   task automatic set_pair(input logic [2:0] hi, input logic [2:0] lo, input logic [7:0] v);
      set_nib(hi, v[7:4]);
      set_nib(lo, v[3:0]);
   endtask

   task automatic set_carry(input logic v);
      @(posedge clk_in);
      carry_wr_in   <= 1'h1;
      carry_data_in <= v;
      @(posedge clk_in);
      carry_wr_in   <= 1'h0;
   endtask

   // issue one instruction; edges count from the taking edge itself, so k execute
   // cycles show done at edge k+1
   task automatic run(input logic [7:0] o1, input logic [7:0] o2, input int len);
      int n;
      n = 1;
      @(posedge clk_in);
      start_in <= 1'h1;
      op1_in   <= o1;
      op2_in   <= o2;
      @(posedge clk_in);
      start_in <= 1'h0;
      #1;
      chk(16'(busy_out), 16'h0001);
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (done_out !== 1'h1 && n < 10);
      if (done_out !== 1'h1) begin
         n_mismatch++;
         wrap_up();
      end else begin
         chk(16'(n), 16'(len));
         chk(16'(busy_out), 16'h0000);
         @(posedge clk_in);
         #1;
         chk(16'(done_out), 16'h0000);
      end
   endtask

   function automatic logic [7:0] pair_of(input int rr);
      return (rr == 1) ? hl : (rr == 2) ? wx : yz;
   endfunction

   task automatic sc_pair_moves;
      logic [7:0] v;
      for (int rr = 1; rr < 4; rr++) begin
         v = {4'(rr), 4'(15 - rr)};
         set_pair(3'h1, 3'h0, v);
         run(8'hDC, 8'(8'hF0 | (rr << 1)), 3);
         chk(16'(pair_of(rr)), 16'(v));
         set_pair(3'h1, 3'h0, ~v);
         run(8'hDC, 8'(8'hF8 | (rr << 1)), 3);
         chk(16'(ea), 16'(v));
      end
      // pair code zero names the accumulator itself: nothing moves
      run(8'hDC, 8'hF0, 3);
      chk(16'(ea), 16'h003C);
   endtask

   task automatic sc_direct;
      logic [7:0] ops [2];
      ops = '{8'h21, 8'h20};
      set_pair(3'h1, 3'h0, 8'hC3);
      run(8'hCD, 8'h21, 3);
      foreach (ops[i]) begin
         set_pair(3'h1, 3'h0, 8'h00);
         run(8'hCE, ops[i], 3);
         chk(16'(ea), 16'h00C3);
      end
   endtask

   task automatic sc_pointer;
      set_pair(3'h3, 3'h2, 8'h45);
      set_pair(3'h1, 3'h0, 8'h96);
      run(8'hDC, 8'h00, 3);
      set_pair(3'h1, 3'h0, 8'h00);
      run(8'hDC, 8'h08, 3);
      chk(16'(ea), 16'h0096);
      chk(16'(hl), 16'h0045);
      set_pair(3'h1, 3'h0, 8'h00);
      run(8'hCE, 8'h44, 3);
      chk(16'(ea), 16'h0096);
   endtask

   task automatic sc_nibble_store;
      set_pair(3'h3, 3'h2, 8'h46);
      set_pair(3'h1, 3'h0, 8'h21);
      run(8'hDC, 8'h00, 3);
      set_nib(3'h2, 4'h7);
      set_nib(3'h0, 4'hD);
      run(8'hC4, 8'h00, 2);
      set_nib(3'h2, 4'h6);
      run(8'hDC, 8'h08, 3);
      chk(16'(ea), 16'h00D1);
   endtask

   task automatic sc_bit_high;
      set_pair(3'h1, 3'h0, 8'h00);
      run(8'hCD, 8'h30, 3);
      set_nib(3'h3, 4'h3);
      set_carry(1'h1);
      run(8'hFC, 8'h20, 3);
      chk(16'(carry_out), 16'h0001);
      run(8'hCE, 8'h30, 3);
      chk(16'(ea), 16'h0004);
      set_carry(1'h0);
      run(8'hF4, 8'h60, 3);
      chk(16'(carry_out), 16'h0001);
      run(8'hF4, 8'h10, 3);
      chk(16'(carry_out), 16'h0000);
   endtask

   task automatic sc_bit_low;
      set_pair(3'h1, 3'h0, 8'h00);
      run(8'hCD, 8'hC2, 3);
      set_nib(3'h2, 4'h9);
      set_carry(1'h1);
      run(8'hFC, 8'h40, 3);
      run(8'hCE, 8'hC2, 3);
      chk(16'(ea), 16'h0002);
      set_carry(1'h0);
      run(8'hF4, 8'h40, 3);
      chk(16'(carry_out), 16'h0001);
      set_nib(3'h2, 4'h8);
      run(8'hF4, 8'h40, 3);
      chk(16'(carry_out), 16'h0000);
   endtask

   task automatic sc_port;
      set_carry(1'h1);
      run(8'hFC, 8'hC2, 3);
      chk(16'(pin_out[8]), 16'h0001);
      chk(pin_oe_n_out, 16'hFEFF);
      set_carry(1'h0);
      run(8'hF4, 8'hC2, 3);
      chk(16'(carry_out), 16'h0001);
      @(posedge clk_in);
      ext_level <= 16'hFFEF;
      set_carry(1'h1);
      run(8'hF4, 8'hC1, 3);
      chk(16'(carry_out), 16'h0000);
   endtask

   // clock enable low mid-instruction freezes the unit; it resumes where it stopped
   task automatic sc_freeze;
      int n;
      n = 0;
      set_pair(3'h1, 3'h0, 8'h5A);
      @(posedge clk_in);
      start_in <= 1'h1;
      op1_in   <= 8'hDC;
      op2_in   <= 8'hF4;
      @(posedge clk_in);
      start_in <= 1'h0;
      ce_in    <= 1'h0;
      repeat (4) @(posedge clk_in);
      #1;
      chk(16'({busy_out, done_out}), 16'h0002);
      chk(16'(wx), 16'h0000);
      @(posedge clk_in);
      ce_in <= 1'h1;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (done_out !== 1'h1 && n < 10);
      if (done_out !== 1'h1) begin
         n_mismatch++;
         wrap_up();
      end else begin
         chk(16'(n), 16'h0002);
         chk(16'(wx), 16'h005A);
      end
   endtask

   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'h0;
      #1;
      chk(16'(ea), 16'h0000);
      chk(pin_oe_n_out, 16'hFFFF);
      chk(16'({busy_out, done_out, carry_out}), 16'h0000);
      sc_freeze();
      sc_pair_moves();
      sc_direct();
      sc_pointer();
      sc_nibble_store();
      sc_bit_high();
      sc_bit_low();
      sc_port();
      wrap_up();
   end
endmodule
